// [fcs_pkg.sv]
/*
 * shared constants for the flash command, status and protection block:
 * register offsets, field positions, reset values, command codes.
 * assumes an 8 KiB array addressed by byte and a 32-bit register bus.
 */
package fcs_pkg;

	localparam int FCS_AXI_AW = 8;
	localparam int FCS_FADDR_W = 13;
	localparam int FCS_BND_W = 7;
	localparam int FCS_BLK_LSB = FCS_FADDR_W - FCS_BND_W;

	localparam logic [7:0] FCS_OFF_PROT = 8'h00;
	localparam logic [7:0] FCS_OFF_STAT = 8'h04;
	localparam logic [7:0] FCS_OFF_ADDR = 8'h08;
	localparam logic [7:0] FCS_OFF_DATA = 8'h0c;
	localparam logic [7:0] FCS_OFF_CODE = 8'h10;
	localparam logic [7:0] FCS_OFF_IRQ_STAT = 8'h14;
	localparam logic [7:0] FCS_OFF_IRQ_CLR = 8'h18;
	localparam logic [7:0] FCS_OFF_IRQ_EN = 8'h1c;

	localparam int FCS_STAT_CBEF_BIT = 7;
	localparam int FCS_STAT_CCF_BIT = 6;
	localparam int FCS_STAT_PVIOL_BIT = 5;
	localparam int FCS_PROT_DIS_BIT = 0;
	localparam int FCS_PROT_BND_LSB = 1;
	localparam int FCS_PROT_BND_MSB = 7;
	localparam int FCS_IRQ_DONE_BIT = 0;
	localparam int FCS_IRQ_VIOL_BIT = 1;

	localparam logic [7:0] FCS_PROT_RST = 8'hff;
	localparam logic [7:0] FCS_BYTE_RST = 8'h00;
	localparam logic [1:0] FCS_IRQ_RST = 2'h0;

	// command codes, arbitrary encoding
	localparam logic [7:0] FCS_CMD_BLANK = 8'h01;
	localparam logic [7:0] FCS_CMD_PROG = 8'h02;
	localparam logic [7:0] FCS_CMD_BURST = 8'h03;
	localparam logic [7:0] FCS_CMD_PAGE_ERASE = 8'h04;
	localparam logic [7:0] FCS_CMD_MASS_ERASE = 8'h05;

	localparam logic [1:0] FCS_RESP_OKAY = 2'h0;
	localparam logic [1:0] FCS_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {FCS_ARR_IDLE, FCS_ARR_REQ, FCS_ARR_RUN} fcs_arr_e;

	function automatic logic fcs_mapped(input logic [7:0] a);
		fcs_mapped = (a[1:0] == 2'h0) && (a <= FCS_OFF_IRQ_EN);
	endfunction : fcs_mapped

	// program, burst and page erase above the boundary block are protected; mass erase hits it
	// unless the boundary is at the very top
	function automatic logic fcs_is_protected(input logic [7:0] prot,
		input logic [7:0] code, input logic [FCS_FADDR_W-1:0] addr);
		logic [FCS_BND_W-1:0] bnd;
		bnd = prot[FCS_PROT_BND_MSB:FCS_PROT_BND_LSB];
		fcs_is_protected = 1'b0;
		if (!prot[FCS_PROT_DIS_BIT]) begin
			if (code == FCS_CMD_MASS_ERASE) begin
				fcs_is_protected = (bnd != {FCS_BND_W{1'b1}});
			end else if (code == FCS_CMD_PROG || code == FCS_CMD_BURST ||
				code == FCS_CMD_PAGE_ERASE) begin
				fcs_is_protected = (addr[FCS_FADDR_W-1:FCS_BLK_LSB] > bnd);
			end
		end
	endfunction : fcs_is_protected

endpackage : fcs_pkg

// [fcs_if.sv]
/*
 * internal carriers: register access strobes and command hand-off.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface fcs_reg_if;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_err;
	logic rd_en;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_err;
	modport bus(output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		input wr_err, rd_data, rd_err);
	modport core(input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		output wr_err, rd_data, rd_err);
endinterface : fcs_reg_if

interface fcs_cmd_if;
	logic launch;
	logic [7:0] code;
	logic [12:0] addr;
	logic [7:0] data;
	logic cbef;
	logic idle;
	modport ctl(output launch, code, addr, data, input cbef, idle);
	modport eng(input launch, code, addr, data, output cbef, idle);
endinterface : fcs_cmd_if

// [fcs_axil_slave.sv]
/*
 * axi4-lite slave front end: takes address and data in either order,
 * issues one register strobe, answers with a registered response.
 * assumes the core decodes combinationally from the strobe address.
 */
`timescale 1ns/1ns
module fcs_axil_slave import fcs_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	fcs_reg_if.bus rif
);
	logic aw_got_ff, w_got_ff, ar_got_ff, awrdy_ff, wrdy_ff, arrdy_ff;
	logic bvalid_ff, rvalid_ff;
	logic [7:0] awaddr_ff, araddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [3:0] wstrb_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic nxt_aw_got, nxt_w_got, nxt_ar_got, nxt_bvalid, nxt_rvalid;
	logic [7:0] nxt_awaddr, nxt_araddr;
	logic [31:0] nxt_wdata, nxt_rdata;
	logic [3:0] nxt_wstrb;
	logic [1:0] nxt_bresp, nxt_rresp;
	logic do_wr, do_rd;

	assign do_wr = aw_got_ff & w_got_ff & ~bvalid_ff;
	assign do_rd = ar_got_ff & ~rvalid_ff;
	assign rif.wr_en = do_wr;
	assign rif.wr_addr = awaddr_ff;
	assign rif.wr_data = wdata_ff;
	assign rif.wr_strb = wstrb_ff;
	assign rif.rd_en = do_rd;
	assign rif.rd_addr = araddr_ff;

	always_comb begin
		nxt_awaddr = (s_axi_awvalid & awrdy_ff) ? s_axi_awaddr : awaddr_ff;
		nxt_wdata = (s_axi_wvalid & wrdy_ff) ? s_axi_wdata : wdata_ff;
		nxt_wstrb = (s_axi_wvalid & wrdy_ff) ? s_axi_wstrb : wstrb_ff;
		nxt_araddr = (s_axi_arvalid & arrdy_ff) ? s_axi_araddr : araddr_ff;
		nxt_aw_got = (aw_got_ff | (s_axi_awvalid & awrdy_ff)) & ~do_wr;
		nxt_w_got = (w_got_ff | (s_axi_wvalid & wrdy_ff)) & ~do_wr;
		nxt_ar_got = (ar_got_ff | (s_axi_arvalid & arrdy_ff)) & ~do_rd;
		nxt_bvalid = do_wr | (bvalid_ff & ~s_axi_bready);
		nxt_rvalid = do_rd | (rvalid_ff & ~s_axi_rready);
		nxt_bresp = do_wr ? (rif.wr_err ? FCS_RESP_SLVERR : FCS_RESP_OKAY) : bresp_ff;
		nxt_rresp = do_rd ? (rif.rd_err ? FCS_RESP_SLVERR : FCS_RESP_OKAY) : rresp_ff;
		nxt_rdata = do_rd ? rif.rd_data : rdata_ff;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			ar_got_ff <= 1'b0;
			awrdy_ff <= 1'b0;
			wrdy_ff <= 1'b0;
			arrdy_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			araddr_ff <= 8'h00;
			wdata_ff <= 32'h0000_0000;
			rdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			bresp_ff <= 2'h0;
			rresp_ff <= 2'h0;
		end else begin
			aw_got_ff <= nxt_aw_got;
			w_got_ff <= nxt_w_got;
			ar_got_ff <= nxt_ar_got;
			awrdy_ff <= ~nxt_aw_got & ~nxt_bvalid;
			wrdy_ff <= ~nxt_w_got & ~nxt_bvalid;
			arrdy_ff <= ~nxt_ar_got & ~nxt_rvalid;
			bvalid_ff <= nxt_bvalid;
			rvalid_ff <= nxt_rvalid;
			awaddr_ff <= nxt_awaddr;
			araddr_ff <= nxt_araddr;
			wdata_ff <= nxt_wdata;
			rdata_ff <= nxt_rdata;
			wstrb_ff <= nxt_wstrb;
			bresp_ff <= nxt_bresp;
			rresp_ff <= nxt_rresp;
		end
	end

	assign s_axi_awready = awrdy_ff;
	assign s_axi_wready = wrdy_ff;
	assign s_axi_arready = arrdy_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;

endmodule : fcs_axil_slave

// [fcs_cmd_engine.sv]
/*
 * one-deep command buffer and array hand-off sequencer.
 * assumes the array raises ack to take a request and pulses done at its end.
 */
`timescale 1ns/1ns
module fcs_cmd_engine import fcs_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	fcs_cmd_if.eng cmd,
	output logic array_req,
	output logic [7:0] array_code,
	output logic [FCS_FADDR_W-1:0] array_addr,
	output logic [7:0] array_data,
	input wire logic array_ack,
	input wire logic array_done
);
	fcs_arr_e arr_ff, nxt_arr;
	logic buf_full_ff, nxt_buf_full, burst_ff, nxt_burst, cbef_ff, idle_ff;
	logic [7:0] bcode_ff, nxt_bcode, bdata_ff, nxt_bdata, ocode_ff, nxt_ocode;
	logic [7:0] odata_ff, nxt_odata;
	logic [FCS_FADDR_W-1:0] baddr_ff, nxt_baddr, oaddr_ff, nxt_oaddr;
	logic hand_off;

	always_comb begin
		nxt_arr = arr_ff;
		nxt_buf_full = buf_full_ff;
		nxt_bcode = bcode_ff;
		nxt_baddr = baddr_ff;
		nxt_bdata = bdata_ff;
		hand_off = 1'b0;
		if (cmd.launch) begin
			nxt_buf_full = 1'b1;
			nxt_bcode = cmd.code;
			nxt_baddr = cmd.addr;
			nxt_bdata = cmd.data;
		end
		case (arr_ff)
			FCS_ARR_IDLE: hand_off = buf_full_ff;
			FCS_ARR_REQ: if (array_ack) nxt_arr = FCS_ARR_RUN;
			FCS_ARR_RUN: begin
				if (array_done) begin
					hand_off = buf_full_ff;
					nxt_arr = FCS_ARR_IDLE;
				end
			end
			default: nxt_arr = FCS_ARR_IDLE;
		endcase
		if (hand_off) begin
			nxt_arr = FCS_ARR_REQ;
			nxt_buf_full = 1'b0;
		end
		nxt_ocode = hand_off ? bcode_ff : ocode_ff;
		nxt_oaddr = hand_off ? baddr_ff : oaddr_ff;
		nxt_odata = hand_off ? bdata_ff : odata_ff;
		nxt_burst = hand_off ? (bcode_ff == FCS_CMD_BURST) : burst_ff;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arr_ff <= FCS_ARR_IDLE;
			buf_full_ff <= 1'b0;
			burst_ff <= 1'b0;
			cbef_ff <= 1'b1;
			idle_ff <= 1'b1;
			bcode_ff <= 8'h00;
			baddr_ff <= '0;
			bdata_ff <= 8'h00;
			ocode_ff <= 8'h00;
			oaddr_ff <= '0;
			odata_ff <= 8'h00;
		end else begin
			arr_ff <= nxt_arr;
			buf_full_ff <= nxt_buf_full;
			burst_ff <= nxt_burst;
			cbef_ff <= ~nxt_buf_full & ((nxt_arr == FCS_ARR_IDLE) | nxt_burst);
			idle_ff <= ~nxt_buf_full & (nxt_arr == FCS_ARR_IDLE);
			bcode_ff <= nxt_bcode;
			baddr_ff <= nxt_baddr;
			bdata_ff <= nxt_bdata;
			ocode_ff <= nxt_ocode;
			oaddr_ff <= nxt_oaddr;
			odata_ff <= nxt_odata;
		end
	end

	assign cmd.cbef = cbef_ff;
	assign cmd.idle = idle_ff;
	assign array_req = (arr_ff == FCS_ARR_REQ);
	assign array_code = ocode_ff;
	assign array_addr = oaddr_ff;
	assign array_data = odata_ff;

endmodule : fcs_cmd_engine

// [flash_command_status_protect.sv]
/*
 * flash command launch, status flags, block protection and interrupt,
 * reached over axi4-lite. assumes a single clock for bus and array side.
 */
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
module flash_command_status_protect import fcs_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic array_req,
	output logic [7:0] array_code,
	output logic [FCS_FADDR_W-1:0] array_addr,
	output logic [7:0] array_data,
	input wire logic array_ack,
	input wire logic array_done,
	output logic irq
);
	fcs_reg_if rif();
	fcs_cmd_if cif();

	logic [7:0] prot_ff, nxt_prot;
	logic [FCS_FADDR_W-1:0] caddr_ff, nxt_caddr;
	logic [7:0] cdata_ff, nxt_cdata;
	logic [7:0] ccode_ff, nxt_ccode;
	logic ccf_ff, nxt_ccf;
	logic pviol_ff, nxt_pviol;
	logic [1:0] irq_stat_ff, nxt_irq_stat;
	logic [1:0] irq_en_ff, nxt_irq_en;
	logic irq_ff, nxt_irq;

	logic wr_lane0, wr_lane1;
	logic wr_prot, wr_stat, wr_addr, wr_data, wr_code, wr_iclr, wr_ien;
	logic launch_try, launch_ok, launch, viol, hit;
	logic [1:0] irq_evt, irq_clr;
	logic [31:0] rd_word;
	logic [7:0] stat_byte;

	fcs_axil_slave u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rif(rif.bus)
	);

	fcs_cmd_engine u_eng (
		.aclk(aclk),
		.aresetn(aresetn),
		.cmd(cif.eng),
		.array_req(array_req),
		.array_code(array_code),
		.array_addr(array_addr),
		.array_data(array_data),
		.array_ack(array_ack),
		.array_done(array_done)
	);

	// write decode
	always_comb begin
		wr_lane0 = rif.wr_en & rif.wr_strb[0];
		wr_lane1 = rif.wr_en & rif.wr_strb[1];
		wr_prot = 1'b0;
		wr_stat = 1'b0;
		wr_addr = 1'b0;
		wr_data = 1'b0;
		wr_code = 1'b0;
		wr_iclr = 1'b0;
		wr_ien = 1'b0;
		if (rif.wr_addr == FCS_OFF_PROT) begin
			wr_prot = wr_lane0;
		end else if (rif.wr_addr == FCS_OFF_STAT) begin
			wr_stat = wr_lane0;
		end else if (rif.wr_addr == FCS_OFF_ADDR) begin
			wr_addr = rif.wr_en;
		end else if (rif.wr_addr == FCS_OFF_DATA) begin
			wr_data = wr_lane0;
		end else if (rif.wr_addr == FCS_OFF_CODE) begin
			wr_code = wr_lane0;
		end else if (rif.wr_addr == FCS_OFF_IRQ_CLR) begin
			wr_iclr = wr_lane0;
		end else if (rif.wr_addr == FCS_OFF_IRQ_EN) begin
			wr_ien = wr_lane0;
		end
		rif.wr_err = ~fcs_mapped(rif.wr_addr);
	end

	// launch and protection check
	always_comb begin
		launch_try = wr_stat & rif.wr_data[FCS_STAT_CBEF_BIT] & cif.cbef;
		// only a burst may join a running burst
		launch_ok = launch_try & (cif.idle | (ccode_ff == FCS_CMD_BURST));
		hit = fcs_is_protected(prot_ff, ccode_ff, caddr_ff);
		viol = launch_ok & hit;
		launch = launch_ok & ~hit;
		cif.launch = launch;
		cif.code = ccode_ff;
		cif.addr = caddr_ff;
		cif.data = cdata_ff;
	end

	// staged command and protection registers
	always_comb begin
		nxt_prot = wr_prot ? rif.wr_data[7:0] : prot_ff;
		nxt_ccode = wr_code ? rif.wr_data[7:0] : ccode_ff;
		nxt_cdata = wr_data ? rif.wr_data[7:0] : cdata_ff;
		nxt_caddr = caddr_ff;
		if (wr_addr && rif.wr_strb[0]) begin
			nxt_caddr[7:0] = rif.wr_data[7:0];
		end
		if (wr_addr && rif.wr_strb[1]) begin
			nxt_caddr[FCS_FADDR_W-1:8] = rif.wr_data[FCS_FADDR_W-1:8];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prot_ff <= FCS_PROT_RST;
			ccode_ff <= FCS_BYTE_RST;
			cdata_ff <= FCS_BYTE_RST;
			caddr_ff <= '0;
		end else begin
			prot_ff <= nxt_prot;
			ccode_ff <= nxt_ccode;
			cdata_ff <= nxt_cdata;
			caddr_ff <= nxt_caddr;
		end
	end

	// status flags and interrupt
	always_comb begin
		// no write path into this flag
		nxt_ccf = launch ? 1'b0 : cif.idle;
		// write one clears; a same-cycle violation wins
		nxt_pviol = viol | (pviol_ff & ~(wr_stat & rif.wr_data[FCS_STAT_PVIOL_BIT]));
		irq_evt = 2'h0;
		irq_evt[FCS_IRQ_DONE_BIT] = nxt_ccf & ~ccf_ff;
		irq_evt[FCS_IRQ_VIOL_BIT] = viol;
		irq_clr = wr_iclr ? rif.wr_data[1:0] : 2'h0;
		// set beats clear
		nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_evt;
		nxt_irq_en = wr_ien ? rif.wr_data[1:0] : irq_en_ff;
		nxt_irq = |(nxt_irq_stat & nxt_irq_en);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ccf_ff <= 1'b1;
			pviol_ff <= 1'b0;
			irq_stat_ff <= FCS_IRQ_RST;
			irq_en_ff <= FCS_IRQ_RST;
			irq_ff <= 1'b0;
		end else begin
			ccf_ff <= nxt_ccf;
			pviol_ff <= nxt_pviol;
			irq_stat_ff <= nxt_irq_stat;
			irq_en_ff <= nxt_irq_en;
			irq_ff <= nxt_irq;
		end
	end

	// read mux; write-only clear register reads as zero
	always_comb begin
		stat_byte = 8'h00;
		stat_byte[FCS_STAT_CBEF_BIT] = cif.cbef;
		stat_byte[FCS_STAT_CCF_BIT] = ccf_ff;
		stat_byte[FCS_STAT_PVIOL_BIT] = pviol_ff;
		rd_word = 32'h0000_0000;
		if (rif.rd_addr == FCS_OFF_PROT) begin
			rd_word[7:0] = prot_ff;
		end else if (rif.rd_addr == FCS_OFF_STAT) begin
			rd_word[7:0] = stat_byte;
		end else if (rif.rd_addr == FCS_OFF_ADDR) begin
			rd_word[FCS_FADDR_W-1:0] = caddr_ff;
		end else if (rif.rd_addr == FCS_OFF_DATA) begin
			rd_word[7:0] = cdata_ff;
		end else if (rif.rd_addr == FCS_OFF_CODE) begin
			rd_word[7:0] = ccode_ff;
		end else if (rif.rd_addr == FCS_OFF_IRQ_STAT) begin
			rd_word[1:0] = irq_stat_ff;
		end else if (rif.rd_addr == FCS_OFF_IRQ_EN) begin
			rd_word[1:0] = irq_en_ff;
		end
		rif.rd_data = rd_word;
		rif.rd_err = ~fcs_mapped(rif.rd_addr);
	end

	assign irq = irq_ff;

endmodule : flash_command_status_protect

// [fcs_props.sv]
/*
 * checker for the flash command block: bus answer timing and array hand-off.
 * assumes it is bound to the top block and sees only its ports.
 */
`timescale 1ns/1ns
module fcs_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic array_req,
	input wire logic array_ack,
	input wire logic array_done,
	input wire logic [7:0] array_code,
	input wire logic [12:0] array_addr,
	input wire logic [7:0] array_data
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_REQ_HOLD: assert property (array_req && !array_ack |=> array_req)
		else $error("array request dropped before ack");
	AST_REQ_CAUSE: assert property ($rose(array_req) |-> $past(s_axi_bvalid) || $past(array_done))
		else $error("array request without launch or hand-off");
	AST_REQ_DROP: assert property (array_req && array_ack |=> !array_req)
		else $error("array request stays after ack");
	AST_CMD_STABLE: assert property (array_req && !array_ack |=> $stable(array_code) && $stable(array_addr) && $stable(array_data))
		else $error("command changed while requested");
	AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
		else $error("read response late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	AST_WR_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
endmodule : fcs_props

bind flash_command_status_protect fcs_props fcs_props_i (.*);

// [fcs_array_model.sv]
/*
 * behavioural flash array: acks a request lat+1 cycles after it appears, raises done 4*lat+1 cycles after the ack.
 * assumes the block holds array_req until ack and ignores done when idle.
 */
`timescale 1ns/1ns
module fcs_array_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic array_req,
	input wire logic [2:0] lat,
	output logic array_ack,
	output logic array_done
);
	logic run_ff;
	logic [5:0] cnt_ff;
	always @(posedge aclk) begin
		array_ack <= 1'b0;
		array_done <= 1'b0;
		if (!aresetn) begin
			run_ff <= 1'b0;
			cnt_ff <= 6'h0;
		end else if (!run_ff) begin
			// slow acks expose the buffered burst path
			if (array_req && !array_ack) begin
				cnt_ff <= (cnt_ff >= {3'h0, lat}) ? 6'h0 : cnt_ff + 6'h1;
				array_ack <= (cnt_ff >= {3'h0, lat});
				run_ff <= (cnt_ff >= {3'h0, lat});
			end
		end else begin
			cnt_ff <= (cnt_ff >= {1'b0, lat, 2'h0}) ? 6'h0 : cnt_ff + 6'h1;
			array_done <= (cnt_ff >= {1'b0, lat, 2'h0});
			run_ff <= !(cnt_ff >= {1'b0, lat, 2'h0});
		end
	end
endmodule : fcs_array_model

// [flash_command_status_protect_tb.sv]
/*
 * self-checking bench: axi4-lite master, reference model with queues.
 * assumes the array model above and the designer's register offsets.
 */
`timescale 1ns/1ns
module flash_command_status_protect_tb;
	import fcs_pkg::*;
	logic aclk = 0;
	logic aresetn = 0;
	logic [7:0] s_axi_awaddr = 0;
	logic [7:0] s_axi_araddr = 0;
	logic s_axi_awvalid = 0;
	logic s_axi_wvalid = 0;
	logic s_axi_bready = 0;
	logic s_axi_arvalid = 0;
	logic s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic array_req, array_ack, array_done, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
	logic [31:0] s_axi_rdata, rv, r;
	logic [7:0] array_code, array_data, c;
	logic [12:0] array_addr;
	logic [2:0] lat = 0;
	int bad_count = 0;
	int checked = 0;
	int seed = 32'h19a8ba7b;
	// late ready exercises the response hold checks
	bit slow = 0;
	logic [7:0] m_prot = 8'hff;
	logic m_viol = 0;
	logic [1:0] m_ist = 0;
	logic [1:0] m_ien = 0;
	logic [28:0] got[$];
	logic [28:0] exp[$];
	logic [31:0] tbl [8] = '{32'h00020040, 32'h02020040, 32'h01050000, 32'hfe050000,
		32'h00050000, 32'h00011fff, 32'h00041fff, 32'h00030000};

	flash_command_status_protect flash_command_status_protect_i (.*);
	fcs_array_model fcs_array_model_i (.*);

	always #2 aclk = ~aclk;
	always @(posedge aclk) begin
		if (array_req && array_ack) got.push_back({array_code, array_addr, array_data});
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude

	task automatic tmo(input int n);
		if (n > 200) begin
			bad_count++;
			conclude();
		end
	endtask : tmo

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic chk_cmd();
		logic [28:0] g;
		logic [28:0] e;
		while (exp.size() || got.size()) begin
			g = got.size() ? got.pop_front() : 'x;
			e = exp.size() ? exp.pop_front() : 'x;
			checked++;
			if (g !== e) begin
				bad_count++;
				$display("[ERR] %0t cmd got %h exp %h", $time, g, e);
			end
		end
	endtask : chk_cmd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= !slow;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid && s_axi_bready) break;
			if (s_axi_bvalid) s_axi_bready <= 1;
			tmo(++n);
		end
		last_resp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= !slow;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_rvalid) s_axi_rready <= 1;
			tmo(++n);
		end
		rv = s_axi_rdata;
		last_resp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask : rd

	task automatic setp(input logic [7:0] p);
		wr(FCS_OFF_PROT, {24'h0, p});
		chk({30'h0, last_resp}, {30'h0, FCS_RESP_OKAY});
		m_prot = p;
		rd(FCS_OFF_PROT);
		chk(rv, {24'h0, p});
	endtask : setp

	task automatic idle();
		int n;
		n = 0;
		rv = 0;
		while (rv[7:6] !== 2'b11) begin
			rd(FCS_OFF_STAT);
			tmo(++n);
		end
	endtask : idle

	task automatic run(input logic [7:0] k, input logic [12:0] a, input logic [7:0] d,
		input bit w);
		logic p;
		// reference protection check at launch
		p = !m_prot[0] && ((k == 8'h05 && m_prot[7:1] != 7'h7f) ||
			((k == 8'h02 || k == 8'h03 || k == 8'h04) && a[12:6] > m_prot[7:1]));
		wr(FCS_OFF_ADDR, {19'h0, a});
		wr(FCS_OFF_DATA, {24'h0, d});
		wr(FCS_OFF_CODE, {24'h0, k});
		wr(FCS_OFF_STAT, 32'h80);
		m_viol = m_viol | p;
		m_ist = m_ist | {p, !p};
		if (!p) exp.push_back({k, a, d});
		if (w) idle();
	endtask : run

	task automatic check_all();
		rd(FCS_OFF_STAT);
		chk(rv, {24'h0, 2'b11, m_viol, 5'h0});
		rd(FCS_OFF_IRQ_STAT);
		chk(rv, {30'h0, m_ist});
		chk({30'h0, last_resp}, {30'h0, FCS_RESP_OKAY});
		chk_cmd();
		chk({31'h0, irq}, {31'h0, |(m_ist & m_ien)});
		wr(FCS_OFF_IRQ_CLR, 32'h3);
		m_ist = 0;
	endtask : check_all

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		rd(FCS_OFF_PROT);
		chk(rv, 32'hff);
		rd(FCS_OFF_STAT);
		chk(rv, 32'hc0);
		wr(8'h40, 32'h1);
		chk({30'h0, last_resp}, {30'h0, FCS_RESP_SLVERR});
		rd(8'h42);
		chk(rv, 32'h0);
		chk({30'h0, last_resp}, {30'h0, FCS_RESP_SLVERR});
		$display("test reset done");
		wr(FCS_OFF_IRQ_EN, 32'h3);
		m_ien = 2'h3;
		foreach (tbl[i]) begin
			setp(tbl[i][31:24]);
			run(tbl[i][23:16], tbl[i][12:0], 8'(i), 1);
			check_all();
		end
		$display("test boundary done");
		wr(FCS_OFF_STAT, 32'h40);
		check_all();
		wr(FCS_OFF_STAT, 32'h0);
		check_all();
		wr(FCS_OFF_STAT, 32'h20);
		m_viol = 0;
		check_all();
		$display("test flags done");
		repeat (12) begin
			r = $random(seed);
			lat <= r[2:0];
			slow = r[11];
			setp(r[7:0]);
			m_ien = r[9:8];
			wr(FCS_OFF_IRQ_EN, {30'h0, r[9:8]});
			c = 8'(r[18:16] % 3'h5) + 8'h1;
			run(c, r[31:19], r[15:8], 1);
			check_all();
		end
		$display("test random done");
		lat <= 3'h7;
		setp(8'hff);
		run(FCS_CMD_BURST, 13'h0100, 8'h5a, 0);
		rd(FCS_OFF_STAT);
		chk({30'h0, rv[7:6]}, 32'h2);
		run(FCS_CMD_BURST, 13'h0101, 8'ha5, 0);
		rd(FCS_OFF_STAT);
		chk({30'h0, rv[7:6]}, 32'h0);
		idle();
		check_all();
		$display("test burst done");
		conclude();
	end
endmodule : flash_command_status_protect_tb
